// File: sbsc_core.sv
// Synchronous control front end of a pipelined burst static memory
// What this block does
// - All synchronous inputs are registered on the rising clock edge.
// - Advance low during a burst steps the burst counter.
// - Selected only when first low, second high, third low together.
// - Processor strobe ignored while first enable is high.
// - Without third enable, behave as if it were always asserted.
// - Output enable low drives data and parity; high makes them inputs.
// - Output enable masked for first read cycle after deselect.
// - Accepted processor strobe captures address and seeds burst counter.
// - Controller strobe captures address and seeds burst counter.
// - Both strobes together: an accepted processor strobe alone is obeyed; with first enable high the controller strobe is obeyed.
// - Sleep input high idles the device, keeping stored data.
// - Input data lines are latched into a write data register.
// - Read data comes from the previous edge's address, one cycle later.
// - Strap low selects linear order, high selects interleaved.
// - Two-bit burst counter cleared at capture; the burst starts from the two lowest address bits.
// - Global write low writes all bytes regardless of byte selects.
module sbsc_core #(
  parameter bit HAS_THIRD_SELECT = 1'b1
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [sbsc_pkg::ADDR_W-1:0] addr_i,
  input wire logic select_low_first_n_i,
  input wire logic select_high_second_i,
  input wire logic select_low_third_n_i,
  input wire logic processor_addr_strobe_n_i,
  input wire logic controller_addr_strobe_n_i,
  input wire logic burst_step_n_i,
  input wire logic write_all_bytes_n_i,
  input wire logic byte_write_gate_n_i,
  input wire logic [sbsc_pkg::BYTES-1:0] byte_select_n_i,
  input wire logic burst_order_i,
  input wire logic out_enable_n_i,
  input wire logic sleep_request_i,
  input wire logic [sbsc_pkg::DATA_W-1:0] data_i,
  input wire logic [sbsc_pkg::PAR_W-1:0] parity_lines_i,
  output logic [sbsc_pkg::DATA_W-1:0] data_o,
  output logic [sbsc_pkg::PAR_W-1:0] parity_lines_o,
  output logic data_oe_o,
  output logic sleeping_o
);
  localparam int LANE = sbsc_pkg::DATA_W / sbsc_pkg::BYTES;
  localparam int WORD = sbsc_pkg::DATA_W + sbsc_pkg::PAR_W;
  localparam int LANE_W = LANE + 1;

  typedef struct packed {
    logic [sbsc_pkg::ADDR_W-1:0] addr;
    logic [sbsc_pkg::BURST_W-1:0] start;
    logic [sbsc_pkg::BURST_W-1:0] count;
    logic active;
    logic was_deselected;
    logic mask_oe;
    logic order;
    logic order_taken;
    logic [WORD-1:0] rdata;
    logic [WORD-1:0] wdata;
    logic wr_pend;
    logic [sbsc_pkg::BYTES-1:0] wr_lanes;
    logic [sbsc_pkg::ADDR_W-1:0] wr_addr;
    logic oe;
  } sbsc_state_t;

  sbsc_state_t q, d;
  // Reset synchroniser sits in the raw reset domain, so it stays outside the state struct
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic oe_n_s, sleep_s;
  logic [WORD-1:0] mem [sbsc_pkg::DEPTH];

  sbsc_sync3 u_sync_oe (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n), .async_i(out_enable_n_i), .sync_o(oe_n_s));
  sbsc_sync3 u_sync_sleep (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n), .async_i(sleep_request_i), .sync_o(sleep_s));

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_sync_q <= 2'h0;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  logic third_ok, selected, p_take, c_take, take;
  logic [sbsc_pkg::BURST_W-1:0] next_count, burst_addr;
  logic [sbsc_pkg::ADDR_W-1:0] cur_addr;
  logic is_write;
  logic [sbsc_pkg::BYTES-1:0] lanes;

  always_comb
  begin
    d = q;
    third_ok = HAS_THIRD_SELECT ? !select_low_third_n_i : 1'b1;
    selected = !select_low_first_n_i && select_high_second_i && third_ok;
    p_take = !processor_addr_strobe_n_i && !select_low_first_n_i;
    c_take = !controller_addr_strobe_n_i && !p_take;
    take = (p_take || c_take) && !sleep_s;
    next_count = q.count + sbsc_pkg::BURST_ONE;
    if (!q.order_taken)
    begin
      d.order = burst_order_i;
      d.order_taken = 1'b1;
    end
    burst_addr = (q.order == sbsc_pkg::MODE_LINEAR) ? (q.start + q.count) : (q.start ^ q.count);
    cur_addr = {q.addr[sbsc_pkg::ADDR_W-1:sbsc_pkg::BURST_W], burst_addr};
    is_write = !write_all_bytes_n_i || (!byte_write_gate_n_i && (byte_select_n_i != '1));
    lanes = !write_all_bytes_n_i ? '1 : ~byte_select_n_i;
    // Write data is committed one edge after capture to match the address
    d.wr_pend = 1'b0;
    d.wdata = {parity_lines_i, data_i};
    d.mask_oe = 1'b0;
    if (take)
    begin
      // processor capture, controller capture, seed counter
      d.addr = addr_i;
      d.start = addr_i[sbsc_pkg::BURST_W-1:0];
      d.count = sbsc_pkg::BURST_ZERO;
      d.active = selected;
      d.was_deselected = !selected;
      d.mask_oe = selected && q.was_deselected;
    end
    else if (q.active && !burst_step_n_i && !sleep_s)
    begin
      d.count = next_count;
    end
    if (q.active && !take && !sleep_s && is_write && !p_take)
    begin
      d.wr_pend = 1'b1;
      d.wr_lanes = lanes;
      d.wr_addr = cur_addr;
    end
    if (q.active)
    begin
      d.rdata = mem[cur_addr];
    end
    d.oe = !oe_n_s && !d.mask_oe && d.active && !sleep_s;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q.addr <= '0;
      q.start <= '0;
      q.count <= '0;
      q.active <= 1'b0;
      q.was_deselected <= 1'b1;
      q.mask_oe <= 1'b0;
      q.order <= sbsc_pkg::MODE_INTERLEAVED;
      q.order_taken <= 1'b0;
      q.rdata <= '0;
      q.wdata <= '0;
      q.wr_pend <= 1'b0;
      q.wr_lanes <= '0;
      q.wr_addr <= '0;
      q.oe <= 1'b0;
    end
    else
    begin
      q.addr <= d.addr;
      q.start <= d.start;
      q.count <= d.count;
      q.active <= d.active;
      q.was_deselected <= d.was_deselected;
      q.mask_oe <= d.mask_oe;
      q.order <= d.order;
      q.order_taken <= d.order_taken;
      q.rdata <= d.rdata;
      q.wdata <= d.wdata;
      q.wr_pend <= d.wr_pend;
      q.wr_lanes <= d.wr_lanes;
      q.wr_addr <= d.wr_addr;
      q.oe <= d.oe;
    end
  end

  // Array kept out of reset so it maps to memory; contents survive sleep
  always_ff @(posedge sys_clk_i)
  begin
    if (q.wr_pend)
    begin
      for (int b = 0; b < sbsc_pkg::BYTES; b++)
      begin
        if (q.wr_lanes[b])
        begin
          mem[q.wr_addr][b*LANE +: LANE] <= q.wdata[b*LANE +: LANE];
          mem[q.wr_addr][sbsc_pkg::DATA_W + b] <= q.wdata[sbsc_pkg::DATA_W + b];
        end
      end
    end
  end

  assign data_o = q.rdata[sbsc_pkg::DATA_W-1:0];
  assign parity_lines_o = q.rdata[WORD-1:sbsc_pkg::DATA_W];
  assign data_oe_o = q.oe;
  assign sleeping_o = sleep_s;
endmodule : sbsc_core

// File: sbsc_core_assertions.sv
// Checker bound to the burst memory front end
module sbsc_core_checker (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic select_low_first_n_i,
  input wire logic select_high_second_i,
  input wire logic select_low_third_n_i,
  input wire logic processor_addr_strobe_n_i,
  input wire logic controller_addr_strobe_n_i,
  input wire logic burst_step_n_i,
  input wire logic write_all_bytes_n_i,
  input wire logic byte_write_gate_n_i,
  input wire logic out_enable_n_i,
  input wire logic sleep_request_i,
  input wire logic [31:0] data_o,
  input wire logic [3:0] parity_lines_o,
  input wire logic data_oe_o,
  input wire logic sleeping_o
);
  logic [2:0] up_q;
  logic qt;
  logic idle;
  logic sel_q, sel_c, take_c;
  // Skip start-up edges while the internal reset copy is still low
  always_ff @(posedge sys_clk_i or negedge nrst_i)
    if (!nrst_i) up_q <= 3'h0;
    else if (!up_q[2]) up_q <= up_q + 3'h1;
  assign qt = up_q[2] & burst_step_n_i & write_all_bytes_n_i & byte_write_gate_n_i;
  assign idle = qt & processor_addr_strobe_n_i & controller_addr_strobe_n_i;
  // Selection seen at the last accepted strobe; the core listens from the third edge after release
  assign sel_c = !select_low_first_n_i && select_high_second_i && !select_low_third_n_i;
  assign take_c = ((!processor_addr_strobe_n_i && !select_low_first_n_i) || !controller_addr_strobe_n_i)
    && !sleeping_o && (up_q >= 3'h2);
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sel_q <= 1'b0;
    end
    else if (take_c)
    begin
      sel_q <= sel_c;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  a_read_hold: assert property (idle [*3] |=> $stable(data_o)) else $error("data moved");
  a_parity_hold: assert property (idle [*3] |=> $stable(parity_lines_o)) else $error("parity moved");
  a_first_gate: assert property ((qt && !processor_addr_strobe_n_i && select_low_first_n_i
    && controller_addr_strobe_n_i) [*3] |=> $stable(data_o)) else $error("gated strobe taken");
  a_sleep_deaf: assert property ((qt && sleeping_o) [*3] |=> $stable(data_o)) else $error("strobe in sleep");
  a_sleep_on: assert property ((up_q[2] && sleep_request_i) [*8] |-> sleeping_o) else $error("no sleep");
  a_sleep_off: assert property ((up_q[2] && !sleep_request_i) [*8] |-> !sleeping_o) else $error("asleep");
  a_oe_off: assert property ((up_q[2] && out_enable_n_i) [*8] |-> !data_oe_o) else $error("drives");
  a_oe_on: assert property ((idle && sel_q && !out_enable_n_i && !sleeping_o) [*8] |-> data_oe_o) else $error("idle");
  a_desel_quiet: assert property (take_c && !sel_c |=> !data_oe_o) else $error("deselected drive");
  a_oe_mask: assert property (take_c && sel_c && !sel_q |=> !data_oe_o) else $error("mask missed");
endmodule : sbsc_core_checker

bind sbsc_core sbsc_core_checker sbsc_core_checker_inst (.*);

// File: sbsc_host_model.sv
// Bus master model presenting requests to the burst memory front end
module sbsc_host_model (
  output logic [18:0] addr_o,
  output logic [11:0] ctl_o,
  output logic [35:0] wr_o
);
  // byte gate and byte selects always travel together
  task automatic drv(input logic [11:0] ctl, input logic [18:0] a, input logic [35:0] w);
    ctl_o = ctl;
    addr_o = a;
    // Fresh pattern every cycle so released lines never repeat stale data
    wr_o = w;
  endtask : drv
endmodule : sbsc_host_model

// File: sbsc_pkg.sv
// Constants shared by the burst memory control front end
package sbsc_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 32;
  localparam int PAR_W = 4;
  localparam int BYTES = 4;
  localparam int BURST_W = 2;
  localparam int DEPTH = 1 << ADDR_W;
  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
  localparam logic MODE_LINEAR = 1'h0;
  localparam logic MODE_INTERLEAVED = 1'h1;
endpackage : sbsc_pkg

// File: sbsc_sync3.sv
// Three-stage synchroniser with agreement check for asynchronous pins
module sbsc_sync3 (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic sync_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic out;
  } sbsc_sync_t;
  sbsc_sync_t q, d;
  always_comb
  begin
    d = q;
    d.s1 = async_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // Change counts only once stages two and three agree
    if (q.s2 == q.s3)
    begin
      d.out = q.s3;
    end
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end
  assign sync_o = q.out;
endmodule : sbsc_sync3

// File: testbench.sv
// Self-checking bench for the burst memory front end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0, nrst_i = 1'b0, mode = 1'b0, oe_n = 1'b0, sleep_req = 1'b0, oe, sleeping;
  logic [18:0] addr;
  logic [11:0] ctl;
  logic [35:0] wr, rd;
  logic [35:0] mem [int];
  int q [$];
  int base, cnt, err_count = 0, checks = 0;
  initial forever #5 sys_clk_i = ~sys_clk_i;
  sbsc_host_model sbsc_host_model_inst (.addr_o(addr), .ctl_o(ctl), .wr_o(wr));
  sbsc_core sbsc_core_inst (.sys_clk_i, .nrst_i, .addr_i(addr), .select_low_first_n_i(ctl[9]),
    .select_high_second_i(ctl[8]), .select_low_third_n_i(ctl[7]), .processor_addr_strobe_n_i(ctl[11]),
    .controller_addr_strobe_n_i(ctl[10]), .burst_step_n_i(ctl[6]), .write_all_bytes_n_i(ctl[5]),
    .byte_write_gate_n_i(ctl[4]), .byte_select_n_i(ctl[3:0]), .burst_order_i(mode), .out_enable_n_i(oe_n),
    .sleep_request_i(sleep_req), .data_i(wr[31:0]), .parity_lines_i(wr[35:32]), .data_o(rd[31:0]),
    .parity_lines_o(rd[35:32]), .data_oe_o(oe), .sleeping_o(sleeping));
  task automatic results();
    if (err_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cyc(input logic [11:0] c, input int a, input bit chk);
    logic [35:0] w;
    int x;
    w = 36'({$urandom(), $urandom()});
    @(negedge sys_clk_i);
    x = q.pop_front();
    if (x >= 0) cmp(rd, mem[x]);
    sbsc_host_model_inst.drv(c, a[18:0], w);
    // strobes refused in sleep, processor strobe first
    if (!sleep_req && ((!c[11] && !c[9]) || !c[10]))
    begin
      base = a;
      cnt = 0;
    end
    else if (!c[6]) cnt++;
    // wrap within a group of four
    x = (base & ~3) | ((mode ? base ^ cnt : base + cnt) & 3);
    if (!c[5]) mem[x] = w;
    else if (!c[4])
      for (int b = 0; b < 4; b++)
        if (!c[b]) {mem[x][32 + b], mem[x][8 * b +: 8]} = {w[32 + b], w[8 * b +: 8]};
    q.push_back(chk ? x : -1);
  endtask : cyc
  task automatic burst(input logic [11:0] s);
    int a;
    a = int'($urandom() & 32'h7FFFF);
    cyc(12'h97F, a, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      cyc(12'hD5F, 0, 1'b0);
      cyc(12'hD60 | 12'($urandom() & 32'hF), 0, 1'b0);
      cyc(12'hD3F, 0, 1'b0);
    end
    cyc(s, a ^ 1, 1'b1);
    repeat (3) cyc(12'hD3F, 0, 1'b1);
    repeat (3) cyc(12'h77F, a ^ 4, 1'b1);
    repeat (4) cyc(12'hD7F, 0, 1'b1);
  endtask : burst
  initial
  begin
    void'($urandom(32'h86AF));
    sbsc_host_model_inst.drv(12'hD7F, 19'h0, 36'h0);
    for (int m = 0; m < 2; m++)
    begin
      // strap moves only while reset is held
      mode = m[0];
      nrst_i = 1'b0;
      repeat (6) @(negedge sys_clk_i);
      nrst_i = 1'b1;
      q = '{-1, -1};
      repeat (3) cyc(12'hD7F, 0, 1'b0);
      burst(12'h97F);
      burst(12'h57F);
      burst(12'h17F);
      cyc(12'h87F, base, 1'b0);
      repeat (8) cyc(12'hD7F, 0, 1'b0);
      cmp({35'h0, oe}, 36'h0);
      cyc(12'h97F, base, 1'b1);
      cyc(12'hD7F, 0, 1'b1);
      cmp({35'h0, oe}, 36'h0);
      cyc(12'hD7F, 0, 1'b1);
      cmp({35'h0, oe}, 36'h1);
      oe_n = 1'b1;
      repeat (8) cyc(12'hD7F, 0, 1'b1);
      cmp({35'h0, oe}, 36'h0);
      // sleep raised only over an idle bus
      sleep_req = 1'b1;
      repeat (8) cyc(12'hD7F, 0, 1'b1);
      cyc(12'h97F, 5, 1'b1);
      repeat (3) cyc(12'hD7F, 0, 1'b1);
      cmp({35'h0, sleeping}, 36'h1);
      sleep_req = 1'b0;
      repeat (8) cyc(12'hD7F, 0, 1'b1);
      cmp({35'h0, sleeping}, 36'h0);
      oe_n = 1'b0;
      repeat (8) cyc(12'hD7F, 0, 1'b1);
      cmp({35'h0, oe}, 36'h1);
    end
    results();
  end
endmodule : testbench
